// >>> flash_write_window_guard_test.sv
`timescale 1ns/1ps
`include "fwg_regs.vh"
module flash_write_window_guard_test;
    localparam [31:0] SMPU_W = 32'h0000_0A5C;
    localparam [31:0] WIN_W = 32'h8004_0002;
    localparam [31:0] ID_W = 32'h1357_9BDF;
    typedef struct packed {
        logic [1:0] m;
        logic [1:0] op;
        logic [31:0] a;
        logic [3:0] e;
    } fwg_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic dbg_req_pin = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] dbg_code_pin = 32'h0;
    logic [1:0] exec_mode = 2'h0;
    logic [31:0] rd;
    logic [3:0] msk = 4'h0;
    wire [31:0] avs_readdata, smpu_cfg, fl_rd_addr, fl_rd_data;
    wire [31:0] fl_cmd_addr, fl_cmd_data;
    wire avs_waitrequest, irq, dbg_grant, cpu_run, fl_rd_req, fl_rd_valid;
    wire fl_cmd_valid, fl_cmd_done;
    wire [1:0] fl_cmd_op;
    int n_mismatch = 0;
    int total_checks = 0;
    int n;
    // blocks 2..3 open: inside, last block, end block, below, outside
    // flash, block 0
    fwg_row_t rows [6] = '{
        {2'h0, 2'h0, 32'h0001_0000, 4'h4},
        {2'h1, 2'h1, 32'h0001_FFFC, 4'h4},
        {2'h2, 2'h0, 32'h0002_0000, 4'h1},
        {2'h3, 2'h1, 32'h0000_8000, 4'h1},
        {2'h1, 2'h1, 32'h0020_0000, 4'h4},
        {2'h0, 2'h0, 32'h0000_0000, 4'h1}};
    initial forever #20 clk = ~clk;
    fwg_top uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .exec_mode,
        .dbg_req_pin, .dbg_code_pin, .dbg_grant, .cpu_run, .smpu_cfg,
        .fl_rd_req, .fl_rd_addr, .fl_rd_valid, .fl_rd_data, .fl_cmd_valid,
        .fl_cmd_op, .fl_cmd_addr, .fl_cmd_data, .fl_cmd_done);
    fwg_flash_model #(.SMPU_W(SMPU_W), .WIN_W(WIN_W), .ID_W(ID_W)) u_fl (
        .clk, .rst_n, .fl_rd_req, .fl_rd_addr, .fl_rd_valid, .fl_rd_data,
        .fl_cmd_valid, .fl_cmd_done);
    task chk(input logic [65:0] got, input logic [65:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= we;
        avs_read <= ~we;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        chk(k < 20, 1'b1);
        if (k >= 20)
            conclude;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task cmd(input logic [1:0] m, input logic [1:0] op,
        input logic [31:0] a, input logic [31:0] wd, input logic [3:0] e);
        int k;
        exec_mode <= m;
        bus(1'b1, `FWG_OFS_ADDR, a);
        bus(1'b1, `FWG_OFS_WDATA, wd);
        bus(1'b1, `FWG_OFS_CTRL, {29'h0, op, 1'b1});
        repeat (3) @(posedge clk);
        chk(fl_cmd_valid, e[2]);
        if (e[2])
        begin
            chk({fl_cmd_op, fl_cmd_addr ^ a, fl_cmd_data ^ wd}, {op, 64'h0});
            for (k = 0; k < 20 && fl_cmd_valid !== 1'b0; k++) @(posedge clk);
            chk(fl_cmd_valid, 1'b0);
            if (k >= 20)
                conclude;
        end
        repeat (2) @(posedge clk);
        bus(1'b0, `FWG_OFS_IRQ, 32'h0);
        chk(rd, e);
        chk(irq, |(e & msk));
        bus(1'b1, `FWG_OFS_IRQ, {28'h0, e});
        bus(1'b0, `FWG_OFS_IRQ, 32'h0);
        chk({rd, irq}, 33'h0);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({cpu_run, avs_waitrequest, fl_cmd_valid}, 3'h2);
        for (n = 0; n < 100 && cpu_run !== 1'b1; n++) @(posedge clk);
        chk({cpu_run, smpu_cfg}, {1'b1, SMPU_W});
        if (n >= 100)
            conclude;
        bus(1'b0, `FWG_OFS_WIN, 32'h0);
        chk(rd, WIN_W);
        bus(1'b0, `FWG_OFS_STAT, 32'h0);
        chk(rd, 32'h0000_000E);
        bus(1'b0, `FWG_OFS_ID, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        msk = 4'h1;
        bus(1'b1, `FWG_OFS_MASK, 32'h1);
        foreach (rows[i]) cmd(rows[i].m, rows[i].op, rows[i].a, 32'h0,
            rows[i].e);
        cmd(2'h0, `FWG_OP_OPTWIN, 32'h0, 32'h8002_0005, 4'h2);
        cmd(2'h0, `FWG_OP_OPTWIN, 32'h0, 32'h8000_0000, 4'h4);
        cmd(2'h0, `FWG_OP_ERASE, 32'h0000_8000, 32'h0, 4'h4);
        cmd(2'h0, `FWG_OP_OPTWIN, 32'h0, 32'h0006_0002, 4'h4);
        cmd(2'h0, `FWG_OP_PROG, 32'h0002_FFFC, 32'h5, 4'h4);
        cmd(2'h0, `FWG_OP_ERASE, 32'h0003_0000, 32'h0, 4'h1);
        cmd(2'h0, `FWG_OP_OPTWIN, 32'h0, WIN_W, 4'h2);
        cmd(2'h0, `FWG_OP_OPTWIN, 32'h0, 32'h0, 4'h2);
        bus(1'b0, `FWG_OFS_WIN, 32'h0);
        chk(rd, 32'h0006_0002);
        cmd(2'h0, `FWG_OP_OPTID, 32'h0, ID_W, 4'h4);
        dbg_code_pin <= ~ID_W;
        dbg_req_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(dbg_grant, 1'b0);
        bus(1'b0, `FWG_OFS_IRQ, 32'h0);
        chk(rd, 32'h8);
        bus(1'b1, `FWG_OFS_IRQ, 32'h8);
        dbg_req_pin <= 1'b0;
        repeat (10) @(posedge clk);
        dbg_code_pin <= ID_W;
        repeat (2) @(posedge clk);
        dbg_req_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(dbg_grant, 1'b1);
        dbg_req_pin <= 1'b0;
        repeat (6) @(posedge clk);
        chk(dbg_grant, 1'b0);
        conclude;
    end
endmodule // flash_write_window_guard_test

// >>> fwg_flash_model.sv
`timescale 1ns/1ps
`include "fwg_regs.vh"
module fwg_flash_model #(
    parameter RD_DLY = 1,
    parameter CMD_DLY = 3,
    parameter [31:0] SMPU_W = 32'h0000_0A5C,
    parameter [31:0] WIN_W = 32'h8004_0002,
    parameter [31:0] ID_W = 32'h1357_9BDF
) (
    input logic clk,
    input logic rst_n,
    input logic fl_rd_req,
    input logic [31:0] fl_rd_addr,
    output logic fl_rd_valid,
    output logic [31:0] fl_rd_data,
    input logic fl_cmd_valid,
    output logic fl_cmd_done
);
    logic [3:0] rcnt_q;
    logic [3:0] ccnt_q;
    logic [31:0] word;
    assign word = (fl_rd_addr == `FWG_SMPU_ADDR) ? SMPU_W :
        (fl_rd_addr == `FWG_CFG_ID_ADDR) ? ID_W : WIN_W;
    // outside the valid cycle the data lines carry junk
    assign fl_rd_data = fl_rd_valid ? word : ~word;
    always @(posedge clk)
    begin
        fl_rd_valid <= 1'b0;
        fl_cmd_done <= 1'b0;
        if (!rst_n)
        begin
            rcnt_q <= 4'h0;
            ccnt_q <= 4'h0;
        end
        else
        begin
            if (fl_rd_req && !fl_rd_valid)
            begin
                rcnt_q <= (rcnt_q == RD_DLY) ? 4'h0 : rcnt_q + 4'h1;
                fl_rd_valid <= rcnt_q == RD_DLY;
            end
            if (fl_cmd_valid && !fl_cmd_done)
            begin
                ccnt_q <= (ccnt_q == CMD_DLY) ? 4'h0 : ccnt_q + 4'h1;
                fl_cmd_done <= ccnt_q == CMD_DLY;
            end
        end
    end
endmodule // fwg_flash_model

// >>> fwg_guard_monitor.sv
`timescale 1ns/1ps
`include "fwg_regs.vh"
module fwg_guard_monitor (
    input logic clk,
    input logic rst_n,
    input logic dbg_req_pin,
    input logic [31:0] dbg_code_pin,
    input logic dbg_grant,
    input logic cpu_run,
    input logic [31:0] smpu_cfg,
    input logic fl_rd_req,
    input logic [31:0] fl_rd_addr,
    input logic fl_rd_valid,
    input logic [31:0] fl_rd_data,
    input logic fl_cmd_valid,
    input logic [1:0] fl_cmd_op,
    input logic [31:0] fl_cmd_addr,
    input logic [31:0] fl_cmd_data,
    input logic fl_cmd_done
);
    logic [31:0] win_q;
    logic [31:0] id_q;
    logic [31:0] smpu_q;
    logic [11:0] blk;
    logic win_on;
    logic rd_ok;
    assign blk = fl_cmd_addr[`FWG_BLK_HI:`FWG_BLK_LO];
    assign win_on = win_q[27:16] != 12'h000 || win_q[11:0] != 12'h000;
    assign rd_ok = fl_rd_valid && rst_n;
    // shadow of the option words as the block should see them
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            win_q <= 32'h0000_0000;
            id_q <= `FWG_ID_ERASED;
            smpu_q <= 32'h0000_0000;
        end
        else
        begin
            if (rd_ok && fl_rd_addr == `FWG_CFG_WIN_ADDR)
                win_q <= fl_rd_data;
            if (rd_ok && fl_rd_addr == `FWG_CFG_ID_ADDR)
                id_q <= fl_rd_data;
            if (rd_ok && fl_rd_addr == `FWG_SMPU_ADDR)
                smpu_q <= fl_rd_data;
            if (fl_cmd_valid && fl_cmd_done && fl_cmd_op == `FWG_OP_OPTWIN)
                win_q <= fl_cmd_data;
            if (fl_cmd_valid && fl_cmd_done && fl_cmd_op == `FWG_OP_OPTID)
                id_q <= fl_cmd_data;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_issue;
        fl_cmd_valid && !fl_cmd_done;
    endsequence
    sequence s_req_ok;
        (dbg_req_pin && cpu_run && dbg_code_pin == id_q)[*4];
    endsequence
    property p_cmd_hold;
        s_issue |=> fl_cmd_valid && $stable(fl_cmd_addr) && $stable(fl_cmd_op);
    endproperty
    property p_cmd_end;
        fl_cmd_valid && fl_cmd_done |=> !fl_cmd_valid;
    endproperty
    property p_in_window;
        fl_cmd_valid && fl_cmd_op <= `FWG_OP_PROG && win_on
            && fl_cmd_addr < `FWG_PF_LIMIT
            |-> blk >= win_q[11:0] && blk < win_q[27:16];
    endproperty
    property p_lock;
        fl_cmd_valid && fl_cmd_op == `FWG_OP_OPTWIN |-> win_q[`FWG_WIN_LOCK];
    endproperty
    property p_cpu_load;
        $rose(cpu_run) |-> $past(fl_rd_valid) && smpu_cfg == smpu_q;
    endproperty
    property p_no_early;
        !cpu_run |-> !fl_cmd_valid;
    endproperty
    property p_grant_ok;
        dbg_grant |-> id_q == `FWG_ID_ERASED || dbg_code_pin == id_q;
    endproperty
    property p_grant_time;
        s_req_ok |=> dbg_grant;
    endproperty
    property p_rd_hold;
        fl_rd_req && !fl_rd_valid |=> fl_rd_req && $stable(fl_rd_addr);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command dropped early");
    a_cmd_end: assert property (p_cmd_end)
        else $error("command not released");
    a_in_window: assert property (p_in_window)
        else $error("command outside window");
    a_lock: assert property (p_lock)
        else $error("window write while locked");
    a_cpu_load: assert property (p_cpu_load)
        else $error("cpu released before load");
    a_no_early: assert property (p_no_early)
        else $error("command before load");
    a_grant_ok: assert property (p_grant_ok)
        else $error("grant with wrong code");
    a_grant_time: assert property (p_grant_time)
        else $error("grant missing");
    a_rd_hold: assert property (p_rd_hold)
        else $error("option fetch changed");
endmodule // fwg_guard_monitor
bind fwg_top fwg_guard_monitor u_mon (.clk, .rst_n, .dbg_req_pin,
    .dbg_code_pin, .dbg_grant, .cpu_run, .smpu_cfg, .fl_rd_req, .fl_rd_addr,
    .fl_rd_valid, .fl_rd_data, .fl_cmd_valid, .fl_cmd_op, .fl_cmd_addr,
    .fl_cmd_data, .fl_cmd_done);

// >>> fwg_idchk.v
`timescale 1ns/1ps
`include "fwg_regs.vh"
module fwg_idchk (
    input wire clk,
    input wire rst_n,
    input wire loaded,
    input wire dbg_req,
    input wire [31:0] dbg_code,
    input wire [31:0] stored_id,
    output wire grant,
    output wire deny_pulse
);
reg grant_q;
reg deny_q;
reg req_prev_q;
wire id_ok;
// an erased id means no protection
assign id_ok = (stored_id == `FWG_ID_ERASED)
               || (dbg_code == stored_id);
always @(posedge clk)
begin
    if (!rst_n)
    begin
        grant_q <= 1'b0;
        deny_q <= 1'b0;
        req_prev_q <= 1'b0;
    end
    else
    begin
        req_prev_q <= dbg_req;
        grant_q <= dbg_req & loaded & id_ok;
        deny_q <= dbg_req & ~req_prev_q & loaded & ~id_ok;
    end
end
assign grant = grant_q;
assign deny_pulse = deny_q;
endmodule // fwg_idchk

// >>> fwg_regs.vh
`ifndef FWG_REGS_VH
`define FWG_REGS_VH
// Summary of operation
// - erase and program inside the window are allowed for secure and non-secure code alike.
// - there is exactly one window and it spans one contiguous address range.
// - only program flash addresses are checked against the window.
// - the window is enforced in self, serial programming and debug modes.
// - window start and end are held as erase block numbers.
// - once the permanent lock bit is clear, no change to the window is accepted.
// - a programmed debug id must match the code a debugger presents, else access is denied.
// - window and id settings are written by an option-write command, not by erase or program.
// - secure region settings are read from the first program flash sector.
// - window and debug id are read from the configuration setting area.
// - secure region settings are loaded and applied before the cpu is released.
// - a window with start and end both zero is disabled, and clearing needs the lock still set.
// - window start is inclusive and window end is the first block after it.

// register byte offsets
`define FWG_OFS_CTRL 8'h00
`define FWG_OFS_ADDR 8'h04
`define FWG_OFS_WDATA 8'h08
`define FWG_OFS_STAT 8'h0C
`define FWG_OFS_IRQ 8'h10
`define FWG_OFS_MASK 8'h14
`define FWG_OFS_WIN 8'h18
`define FWG_OFS_SMPU 8'h1C
`define FWG_OFS_ID 8'h20

// command codes in ctrl[2:1]
`define FWG_OP_ERASE 2'h0
`define FWG_OP_PROG 2'h1
`define FWG_OP_OPTWIN 2'h2
`define FWG_OP_OPTID 2'h3

// option word layout
`define FWG_WIN_LOCK 31
`define FWG_WIN_END_HI 27
`define FWG_WIN_END_LO 16
`define FWG_WIN_ST_HI 11
`define FWG_WIN_ST_LO 0

// block number bits of a flash address (32 KB blocks)
`define FWG_BLK_HI 26
`define FWG_BLK_LO 15
`define FWG_PF_LIMIT 32'h0020_0000

// option fetch addresses
`define FWG_SMPU_ADDR 32'h0000_0400
`define FWG_CFG_WIN_ADDR 32'h0100_0010
`define FWG_CFG_ID_ADDR 32'h0100_0020
`define FWG_ID_ERASED 32'hFFFF_FFFF

// irq bits
`define FWG_IRQ_BLOCKED 0
`define FWG_IRQ_LOCKREF 1
`define FWG_IRQ_DONE 2
`define FWG_IRQ_DBGDENY 3
`define FWG_IRQ_W 4
`endif

// >>> fwg_sync.v
`timescale 1ns/1ps
module fwg_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
reg [W-1:0] meta_q;
reg [W-1:0] sync_q;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        meta_q <= {W{1'b0}};
        sync_q <= {W{1'b0}};
    end
    else
    begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end
assign sync_out = sync_q;
endmodule // fwg_sync

// >>> fwg_top.v
`timescale 1ns/1ps
`include "fwg_regs.vh"
module fwg_top (
    input wire clk,
    input wire rst_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire irq,
    input wire [1:0] exec_mode,
    input wire dbg_req_pin,
    input wire [31:0] dbg_code_pin,
    output wire dbg_grant,
    output wire cpu_run,
    output wire [31:0] smpu_cfg,
    output wire fl_rd_req,
    output wire [31:0] fl_rd_addr,
    input wire fl_rd_valid,
    input wire [31:0] fl_rd_data,
    output wire fl_cmd_valid,
    output wire [1:0] fl_cmd_op,
    output wire [31:0] fl_cmd_addr,
    output wire [31:0] fl_cmd_data,
    input wire fl_cmd_done
);
localparam [2:0] ST_LOAD = 3'b001;
localparam [2:0] ST_IDLE = 3'b010;
localparam [2:0] ST_ISSUE = 3'b100;

reg [2:0] state_q;
reg [1:0] load_idx_q;
reg loaded_q;
reg wait_q;
reg [31:0] rdata_q;
reg [31:0] cmd_addr_q;
reg [31:0] cmd_data_q;
reg [11:0] win_st_q;
reg [11:0] win_end_q;
reg lock_q;
reg [31:0] id_q;
reg [31:0] smpu_q;
reg [`FWG_IRQ_W-1:0] irq_stat_q;
reg [`FWG_IRQ_W-1:0] irq_mask_q;
reg irq_q;
reg rd_req_q;
reg [31:0] rd_addr_q;
reg cmd_valid_q;
reg [1:0] cmd_op_q;
reg [31:0] fl_addr_q;
reg [31:0] fl_data_q;
reg ev_blocked;
reg ev_lockref;
reg ev_done;
reg [`FWG_IRQ_W-1:0] ev_vec;
reg [31:0] rdata_d;

wire dbg_req_s;
wire [31:0] dbg_code_s;
wire grant_w;
wire deny_w;
wire wr_acc;
wire go;
wire [1:0] go_op;
wire in_pf;
wire [11:0] blk;
wire win_en;
wire in_win;
wire [11:0] new_st;
wire [11:0] new_end;

fwg_sync #(.W(33)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({dbg_req_pin, dbg_code_pin}),
    .sync_out({dbg_req_s, dbg_code_s})
);

fwg_idchk u_idchk (
    .clk(clk),
    .rst_n(rst_n),
    .loaded(loaded_q),
    .dbg_req(dbg_req_s),
    .dbg_code(dbg_code_s),
    .stored_id(id_q),
    .grant(grant_w),
    .deny_pulse(deny_w)
);

// bus write takes effect in the cycle waitrequest is low
assign wr_acc = avs_write & ~wait_q;
assign go = wr_acc && (avs_address == `FWG_OFS_CTRL) && avs_writedata[0];
assign go_op = avs_writedata[2:1];

// window decode works on block numbers only
assign blk = cmd_addr_q[`FWG_BLK_HI:`FWG_BLK_LO];
assign in_pf = cmd_addr_q < `FWG_PF_LIMIT;
assign win_en = (win_st_q != 12'h000) || (win_end_q != 12'h000);
// start inclusive, end exclusive, single range
assign in_win = (blk >= win_st_q) && (blk < win_end_q);
assign new_st = cmd_data_q[`FWG_WIN_ST_HI:`FWG_WIN_ST_LO];
assign new_end = cmd_data_q[`FWG_WIN_END_HI:`FWG_WIN_END_LO];

// avalon slave: one wait cycle, then data and ack
always @(posedge clk)
begin
    if (!rst_n)
        wait_q <= 1'b1;
    else
        wait_q <= ~((avs_read | avs_write) & wait_q);
end

always @*
begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
        `FWG_OFS_ADDR: rdata_d = cmd_addr_q;
        `FWG_OFS_WDATA: rdata_d = cmd_data_q;
        `FWG_OFS_STAT: rdata_d = {25'h0, exec_mode, grant_w, win_en,
                                   lock_q, loaded_q, ~state_q[1]};
        `FWG_OFS_IRQ: rdata_d = {28'h0, irq_stat_q};
        `FWG_OFS_MASK: rdata_d = {28'h0, irq_mask_q};
        `FWG_OFS_WIN: rdata_d = {lock_q, 3'h0, win_end_q, 4'h0, win_st_q};
        `FWG_OFS_SMPU: rdata_d = smpu_q;
        `FWG_OFS_ID: rdata_d = 32'h0000_0000;
        default: rdata_d = 32'h0000_0000;
    endcase
end

always @(posedge clk)
begin
    if (!rst_n)
        rdata_q <= 32'h0000_0000;
    else if (avs_read & wait_q)
        rdata_q <= rdata_d;
end

// command staging registers, frozen while a command is in flight
always @(posedge clk)
begin
    if (!rst_n)
    begin
        cmd_addr_q <= 32'h0000_0000;
        cmd_data_q <= 32'h0000_0000;
        irq_mask_q <= {`FWG_IRQ_W{1'b0}};
    end
    else if (wr_acc)
    begin
        if (avs_address == `FWG_OFS_ADDR && state_q == ST_IDLE)
            cmd_addr_q <= avs_writedata;
        if (avs_address == `FWG_OFS_WDATA && state_q == ST_IDLE)
            cmd_data_q <= avs_writedata;
        if (avs_address == `FWG_OFS_MASK)
            irq_mask_q <= avs_writedata[`FWG_IRQ_W-1:0];
    end
end

// main sequencer: option load, then command check and issue
always @(posedge clk)
begin
    if (!rst_n)
    begin
        state_q <= ST_LOAD;
        load_idx_q <= 2'h0;
        loaded_q <= 1'b0;
        rd_req_q <= 1'b0;
        rd_addr_q <= 32'h0000_0000;
        win_st_q <= 12'h000;
        win_end_q <= 12'h000;
        lock_q <= 1'b1;
        id_q <= `FWG_ID_ERASED;
        smpu_q <= 32'h0000_0000;
        cmd_valid_q <= 1'b0;
        cmd_op_q <= `FWG_OP_ERASE;
        fl_addr_q <= 32'h0000_0000;
        fl_data_q <= 32'h0000_0000;
        ev_blocked <= 1'b0;
        ev_lockref <= 1'b0;
        ev_done <= 1'b0;
    end
    else
    begin
        ev_blocked <= 1'b0;
        ev_lockref <= 1'b0;
        ev_done <= 1'b0;
        case (state_q)
            ST_LOAD:
            begin
                if (!rd_req_q)
                begin
                    rd_req_q <= 1'b1;
                    // secure regions first, so they hold before cpu runs
                    case (load_idx_q)
                        2'h0: rd_addr_q <= `FWG_SMPU_ADDR;
                        2'h1: rd_addr_q <= `FWG_CFG_WIN_ADDR;
                        default: rd_addr_q <= `FWG_CFG_ID_ADDR;
                    endcase
                end
                else if (fl_rd_valid)
                begin
                    rd_req_q <= 1'b0;
                    case (load_idx_q)
                        2'h0: smpu_q <= fl_rd_data;
                        2'h1:
                        begin
                            win_st_q <=
                                fl_rd_data[`FWG_WIN_ST_HI:`FWG_WIN_ST_LO];
                            win_end_q <=
                                fl_rd_data[`FWG_WIN_END_HI:`FWG_WIN_END_LO];
                            lock_q <= fl_rd_data[`FWG_WIN_LOCK];
                        end
                        default: id_q <= fl_rd_data;
                    endcase
                    if (load_idx_q == 2'h2)
                    begin
                        loaded_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                        load_idx_q <= load_idx_q + 2'h1;
                end
            end
            ST_IDLE:
            begin
                if (go)
                begin
                    cmd_op_q <= go_op;
                    fl_addr_q <= cmd_addr_q;
                    fl_data_q <= cmd_data_q;
                    case (go_op)
                        `FWG_OP_OPTWIN:
                        begin
                            // option area: own command, lock is one-way
                            if (!lock_q || new_st > new_end)
                                ev_lockref <= 1'b1;
                            else
                            begin
                                cmd_valid_q <= 1'b1;
                                state_q <= ST_ISSUE;
                            end
                        end
                        `FWG_OP_OPTID:
                        begin
                            cmd_valid_q <= 1'b1;
                            state_q <= ST_ISSUE;
                        end
                        default:
                        begin
                            // same check whatever the mode or caller
                            if (in_pf && win_en && !in_win)
                                ev_blocked <= 1'b1;
                            else
                            begin
                                cmd_valid_q <= 1'b1;
                                state_q <= ST_ISSUE;
                            end
                        end
                    endcase
                end
            end
            ST_ISSUE:
            begin
                if (fl_cmd_done)
                begin
                    cmd_valid_q <= 1'b0;
                    ev_done <= 1'b1;
                    state_q <= ST_IDLE;
                    if (cmd_op_q == `FWG_OP_OPTWIN)
                    begin
                        win_st_q <= fl_data_q[`FWG_WIN_ST_HI:`FWG_WIN_ST_LO];
                        win_end_q <=
                            fl_data_q[`FWG_WIN_END_HI:`FWG_WIN_END_LO];
                        lock_q <= fl_data_q[`FWG_WIN_LOCK];
                    end
                    if (cmd_op_q == `FWG_OP_OPTID)
                        id_q <= fl_data_q;
                end
            end
            default:
                state_q <= ST_LOAD;
        endcase
    end
end

// sticky events; a new event wins over a write-one clear
always @*
begin
    ev_vec = {`FWG_IRQ_W{1'b0}};
    ev_vec[`FWG_IRQ_BLOCKED] = ev_blocked;
    ev_vec[`FWG_IRQ_LOCKREF] = ev_lockref;
    ev_vec[`FWG_IRQ_DONE] = ev_done;
    ev_vec[`FWG_IRQ_DBGDENY] = deny_w;
end

always @(posedge clk)
begin
    if (!rst_n)
    begin
        irq_stat_q <= {`FWG_IRQ_W{1'b0}};
        irq_q <= 1'b0;
    end
    else
    begin
        if (wr_acc && avs_address == `FWG_OFS_IRQ)
            irq_stat_q <= (irq_stat_q & ~avs_writedata[`FWG_IRQ_W-1:0])
                          | ev_vec;
        else
            irq_stat_q <= irq_stat_q | ev_vec;
        irq_q <= |(irq_stat_q & irq_mask_q);
    end
end

assign avs_readdata = rdata_q;
assign avs_waitrequest = wait_q;
assign irq = irq_q;
assign dbg_grant = grant_w;
assign cpu_run = loaded_q;
assign smpu_cfg = smpu_q;
assign fl_rd_req = rd_req_q;
assign fl_rd_addr = rd_addr_q;
assign fl_cmd_valid = cmd_valid_q;
assign fl_cmd_op = cmd_op_q;
assign fl_cmd_addr = fl_addr_q;
assign fl_cmd_data = fl_data_q;
endmodule // fwg_top
